// >>> include/scal_pkg.sv
// Constants and types shared by the sensor output calibration block
package scal_pkg;

    // ****************************************************************
    // Serial frame layout
    // ****************************************************************
    localparam int WR_BIT = 15;
    localparam int ADR_HI = 13;
    localparam int ADR_LO = 8;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] CNT_CAP = 5'h11;

    // ****************************************************************
    // Byte addresses (even byte of each word)
    // ****************************************************************
    localparam logic [5:0] ADR_CMD = 6'h3e;
    // Channel order: accel X, accel Y, tilt X, tilt Y
    localparam int NUM_CH = 4;
    localparam logic [3:0][5:0] RES_ADR = {6'h0e, 6'h0c, 6'h06, 6'h04};
    localparam logic [3:0][5:0] OFF_ADR = {6'h1a, 6'h18, 6'h12, 6'h10};
    localparam logic [3:0][5:0] GAIN_ADR = {6'h1e, 6'h1c, 6'h16, 6'h14};

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam logic [15:0] OFF_RST = 16'h0000;
    localparam logic [15:0] GAIN_RST = 16'h0800;
    localparam logic [15:0] GAIN_MASK = 16'h0fff;
    localparam logic [3:0][15:0] OFF_MASK =
        {16'h01ff, 16'h01ff, 16'h0fff, 16'h0fff};
    localparam int ACC_OFF_W = 12;
    localparam int TLT_OFF_W = 9;
    localparam int CMD_NULL_BIT = 0;
    localparam int CMD_FLASH_BIT = 3;

    // ****************************************************************
    // Datapath widths
    // ****************************************************************
    localparam int RAW_W = 14;
    localparam int GAIN_W = 12;
    localparam int OFF_W = 12;
    localparam int SUM_W = 16;
    localparam int PROD_W = 29;
    localparam int GAIN_SHIFT = 11;
    localparam logic signed [13:0] RES_MAX = 14'sh1fff;
    localparam logic signed [13:0] RES_MIN = 14'sh2000;

    // ****************************************************************
    // Serial port states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FRAME = 2'b10
    } scal_state_e;

endpackage

// >>> verilog/scal_cal_unit.sv
// One calibration channel: result = gain x (raw + offset) / 2048, saturated
`timescale 1ns/1ps
module scal_cal_unit #(
    parameter int OFF_BITS = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sample and calibration words
    input wire logic sample,
    input wire logic zero,
    input wire logic signed [13:0] raw,
    input wire logic [15:0] offset,
    input wire logic [15:0] gain,
    // Results
    output logic signed [13:0] result,
    output logic [15:0] null_offset
);

    localparam int OW = scal_pkg::OFF_W;
    localparam int SW = scal_pkg::SUM_W;
    localparam int PW = scal_pkg::PROD_W;
    localparam int RW = scal_pkg::RAW_W;
    localparam logic signed [15:0] OFF_HI = 16'((1 << (OFF_BITS - 1)) - 1);
    localparam logic signed [15:0] OFF_LO = 16'(-(1 << (OFF_BITS - 1)));
    localparam logic [15:0] OFF_FIELD = 16'((1 << OFF_BITS) - 1);

    logic signed [11:0] off_s;
    logic signed [15:0] sum;
    logic signed [28:0] prod;
    logic signed [28:0] scaled;
    logic signed [15:0] neg_raw;
    logic signed [15:0] clip;
    logic signed [13:0] result_r;
    logic signed [13:0] result_nxt;

    // ****************************************************************
    // Arithmetic
    // ****************************************************************
    // Offset is two's complement, gain is plain binary
    assign off_s = OW'($signed(offset[OFF_BITS-1:0]));
    assign sum = SW'(raw) + SW'(off_s);
    assign prod = PW'(sum) * PW'($signed({1'b0, gain[11:0]}));
    assign scaled = prod >>> scal_pkg::GAIN_SHIFT;

    // Null offset cancels the present raw value, clipped to the field
    assign neg_raw = -SW'(raw);
    always_comb
    begin
        clip = neg_raw;
        if (neg_raw > OFF_HI)
            clip = OFF_HI;
        else if (neg_raw < OFF_LO)
            clip = OFF_LO;
    end
    assign null_offset = clip & OFF_FIELD;

    // ****************************************************************
    // Result register
    // ****************************************************************
    always_comb
    begin
        result_nxt = result_r;
        if (zero)
            result_nxt = '0;
        else if (sample)
        begin
            // Saturate rather than wrap on overflow
            if (scaled > PW'(scal_pkg::RES_MAX))
                result_nxt = scal_pkg::RES_MAX;
            else if (scaled < PW'(scal_pkg::RES_MIN))
                result_nxt = scal_pkg::RES_MIN;
            else
                result_nxt = RW'(scaled);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            result_r <= '0;
        else
            result_r <= result_nxt;
    end

    assign result = result_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_null_zero: assert property (zero |=> result == 14'sh0000)
        else $error("result not cleared by null");
    a_unity_pass: assert property (
        sample && !zero && gain == scal_pkg::GAIN_RST && off_s == 12'sh000
        |=> result == $past(raw))
        else $error("unity gain zero offset does not pass raw");
    a_no_wrap: assert property (
        sample && !zero && sum > 16'sh0000 |=> result >= 14'sh0000)
        else $error("positive sum wrapped negative");
    a_gain_unsigned: assert property (
        sample && !zero && gain[11] && sum > 16'sh0000
        |=> result >= $past(sum[13:0]) || result == scal_pkg::RES_MAX)
        else $error("high gain treated as negative");
    a_signed_off: assert property (
        sample && !zero && raw == 14'sh0000 && gain == scal_pkg::GAIN_RST
        && offset[OFF_BITS-1] |=> result < 14'sh0000)
        else $error("negative offset not applied");

endmodule // scal_cal_unit

// >>> verilog/scal_top.sv
// Sensor output calibration: serial register port and four channels
`timescale 1ns/1ps
module scal_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // Serial register port
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic DIN,
    output logic DOUT,
    output logic DOUT_OE,
    // Raw sensor samples
    input wire logic RAW_VALID,
    input wire logic signed [13:0] RAW_ACC_X,
    input wire logic signed [13:0] RAW_ACC_Y,
    input wire logic signed [13:0] RAW_TLT_X,
    input wire logic signed [13:0] RAW_TLT_Y,
    // Nonvolatile store
    input wire logic NV_LOAD,
    input wire logic [2:0] NV_INDEX,
    input wire logic [15:0] NV_WORD_IN,
    output logic NV_STORE,
    output logic [15:0] NV_WORD_OUT
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] sclk_r;
    logic [2:0] cs_r;
    logic [1:0] din_r;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sclk_r <= 3'h7;
            cs_r <= 3'h7;
            din_r <= 2'h0;
        end
        else
        begin
            sclk_r <= {sclk_r[1:0], SCLK};
            cs_r <= {cs_r[1:0], CS_N};
            din_r <= {din_r[0], DIN};
        end
    end

    // Edges look only at the second and third stages
    assign sclk_rise = sclk_r[1] & ~sclk_r[2];
    assign sclk_fall = ~sclk_r[1] & sclk_r[2];
    assign cs_fall = ~cs_r[1] & cs_r[2];
    assign cs_rise = cs_r[1] & ~cs_r[2];

    // ****************************************************************
    // Calibration channels
    // ****************************************************************
    logic signed [13:0] raw_w [scal_pkg::NUM_CH];
    logic signed [13:0] res_w [scal_pkg::NUM_CH];
    logic [15:0] null_off_w [scal_pkg::NUM_CH];
    logic [15:0] off_r [scal_pkg::NUM_CH];
    logic [15:0] off_nxt [scal_pkg::NUM_CH];
    logic [15:0] gain_r [scal_pkg::NUM_CH];
    logic [15:0] gain_nxt [scal_pkg::NUM_CH];
    logic null_r;
    logic null_nxt;

    assign raw_w[0] = RAW_ACC_X;
    assign raw_w[1] = RAW_ACC_Y;
    assign raw_w[2] = RAW_TLT_X;
    assign raw_w[3] = RAW_TLT_Y;

    // Each channel has a private offset and gain pair
    for (genvar ch = 0; ch < scal_pkg::NUM_CH; ch++)
    begin : g_ch
        scal_cal_unit #(
            .OFF_BITS(ch < 2 ? scal_pkg::ACC_OFF_W : scal_pkg::TLT_OFF_W)
        ) u_cal (
            .clk(CLOCK),
            .rst_n(RESET_N),
            .sample(RAW_VALID),
            .zero(null_r),
            .raw(raw_w[ch]),
            .offset(off_r[ch]),
            .gain(gain_r[ch]),
            .result(res_w[ch]),
            .null_offset(null_off_w[ch])
        );

        a_field_clear: assert property (@(posedge CLOCK)
            disable iff (!RESET_N)
            (off_r[ch] & ~scal_pkg::OFF_MASK[ch]) == 16'h0000
            && (gain_r[ch] & ~scal_pkg::GAIN_MASK) == 16'h0000)
            else $error("unused calibration bits set");
        a_null_load: assert property (@(posedge CLOCK)
            disable iff (!RESET_N)
            null_r |=> off_r[ch] == $past(null_off_w[ch]))
            else $error("null did not load offset");
    end

    // ****************************************************************
    // Serial port and register file
    // ****************************************************************
    scal_pkg::scal_state_e state_r;
    scal_pkg::scal_state_e state_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [15:0] rx_r;
    logic [15:0] rx_nxt;
    logic [15:0] tx_r;
    logic [15:0] tx_nxt;
    logic [15:0] rd_word_r;
    logic [15:0] rd_word_nxt;
    logic dout_r;
    logic dout_nxt;
    logic oe_r;
    logic oe_nxt;
    logic nv_store_r;
    logic nv_store_nxt;
    logic [15:0] nv_word_r;
    logic [15:0] nv_word_nxt;
    logic [5:0] rx_adr;
    logic frame_end;

    assign rx_adr = rx_r[scal_pkg::ADR_HI:scal_pkg::ADR_LO];
    assign frame_end = state_r == scal_pkg::ST_FRAME && cs_rise
        && cnt_r == scal_pkg::FRAME_LEN;

    function automatic logic [15:0] put_byte(input logic [15:0] w,
        input logic hi, input logic [7:0] b);
        put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
    endfunction

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        rd_word_nxt = rd_word_r;
        dout_nxt = dout_r;
        oe_nxt = ~cs_r[1];
        off_nxt = off_r;
        gain_nxt = gain_r;
        null_nxt = 1'b0;
        nv_store_nxt = 1'b0;
        nv_word_nxt = NV_INDEX[2] ? gain_r[NV_INDEX[1:0]]
            : off_r[NV_INDEX[1:0]];
        // Restore from the nonvolatile store
        if (NV_LOAD)
        begin
            if (NV_INDEX[2])
                gain_nxt[NV_INDEX[1:0]] = NV_WORD_IN
                    & scal_pkg::GAIN_MASK;
            else
                off_nxt[NV_INDEX[1:0]] = NV_WORD_IN
                    & scal_pkg::OFF_MASK[NV_INDEX[1:0]];
        end
        if (null_r)
            off_nxt = null_off_w;
        case (state_r)
            scal_pkg::ST_IDLE:
            begin
                if (cs_fall)
                begin
                    state_nxt = scal_pkg::ST_FRAME;
                    cnt_nxt = '0;
                    // Word fetched by the previous read frame
                    tx_nxt = rd_word_r;
                end
            end
            scal_pkg::ST_FRAME:
            begin
                if (sclk_rise && cnt_r != scal_pkg::CNT_CAP)
                begin
                    rx_nxt = {rx_r[14:0], din_r[1]};
                    cnt_nxt = cnt_r + 5'h01;
                end
                if (sclk_fall)
                begin
                    dout_nxt = tx_r[15];
                    tx_nxt = {tx_r[14:0], 1'b0};
                end
                if (cs_rise)
                    state_nxt = scal_pkg::ST_IDLE;
                // Frames of any other length are dropped
                if (frame_end && rx_r[scal_pkg::WR_BIT])
                begin
                    for (int ch = 0; ch < scal_pkg::NUM_CH; ch++)
                    begin
                        if (rx_adr[5:1] == scal_pkg::OFF_ADR[ch][5:1])
                            off_nxt[ch] = put_byte(off_r[ch], rx_adr[0],
                                rx_r[7:0]) & scal_pkg::OFF_MASK[ch];
                        if (rx_adr[5:1] == scal_pkg::GAIN_ADR[ch][5:1])
                            gain_nxt[ch] = put_byte(gain_r[ch], rx_adr[0],
                                rx_r[7:0]) & scal_pkg::GAIN_MASK;
                    end
                    if (rx_adr == scal_pkg::ADR_CMD)
                    begin
                        null_nxt = rx_r[scal_pkg::CMD_NULL_BIT];
                        nv_store_nxt = rx_r[scal_pkg::CMD_FLASH_BIT];
                    end
                end
                else if (frame_end)
                begin
                    // Odd and even address fetch the same whole word
                    rd_word_nxt = 16'h0000;
                    for (int ch = 0; ch < scal_pkg::NUM_CH; ch++)
                    begin
                        if (rx_adr[5:1] == scal_pkg::RES_ADR[ch][5:1])
                            rd_word_nxt = 16'(res_w[ch]);
                        if (rx_adr[5:1] == scal_pkg::OFF_ADR[ch][5:1])
                            rd_word_nxt = off_r[ch];
                        if (rx_adr[5:1] == scal_pkg::GAIN_ADR[ch][5:1])
                            rd_word_nxt = gain_r[ch];
                    end
                end
            end
            default:
                state_nxt = scal_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state_r <= scal_pkg::ST_IDLE;
            cnt_r <= '0;
            rx_r <= '0;
            tx_r <= '0;
            rd_word_r <= '0;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            null_r <= 1'b0;
            nv_store_r <= 1'b0;
            nv_word_r <= '0;
            for (int ch = 0; ch < scal_pkg::NUM_CH; ch++)
            begin
                off_r[ch] <= scal_pkg::OFF_RST;
                gain_r[ch] <= scal_pkg::GAIN_RST;
            end
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            rd_word_r <= rd_word_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            null_r <= null_nxt;
            nv_store_r <= nv_store_nxt;
            nv_word_r <= nv_word_nxt;
            off_r <= off_nxt;
            gain_r <= gain_nxt;
        end
    end

    assign DOUT = dout_r;
    assign DOUT_OE = oe_r;
    assign NV_STORE = nv_store_r;
    assign NV_WORD_OUT = nv_word_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    sequence s_frame_open;
        state_r == scal_pkg::ST_IDLE && cs_fall;
    endsequence
    sequence s_read_end(logic [5:0] adr);
        frame_end && !rx_r[scal_pkg::WR_BIT] && rx_adr == adr;
    endsequence

    a_read_load: assert property (
        s_frame_open |=> tx_r == $past(rd_word_r))
        else $error("read word not loaded at frame start");
    a_read_pair: assert property (
        s_read_end({scal_pkg::OFF_ADR[0][5:1], 1'b1})
        |=> rd_word_r == $past(off_r[0]))
        else $error("odd address read wrong word");
    a_gain_write: assert property (
        frame_end && rx_r[scal_pkg::WR_BIT] && !NV_LOAD
        && rx_adr == scal_pkg::GAIN_ADR[0]
        |=> gain_r[0] == ({$past(gain_r[0][15:8]), $past(rx_r[7:0])}
        & scal_pkg::GAIN_MASK))
        else $error("gain byte write lost");
    a_null_cmd: assert property (
        frame_end && rx_r[scal_pkg::WR_BIT] && rx_adr == scal_pkg::ADR_CMD
        && rx_r[scal_pkg::CMD_NULL_BIT] |=> null_r ##1 !null_r)
        else $error("null command not a one-cycle pulse");
    a_store_pulse: assert property (NV_STORE |=> !NV_STORE)
        else $error("store strobe longer than one cycle");
    a_oe_follow: assert property (cs_r[1] |=> !DOUT_OE)
        else $error("output driven while deselected");

endmodule // scal_top

// >>> verification/scal_spi_host.sv
// Serial host model that frames register reads and writes
`timescale 1ns/1ps
module scal_spi_host (
    // Clock
    input wire logic clk,
    // Serial lines
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic miso
);
    // ****************************************************************
    // Frame engine
    // ****************************************************************
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b1;
    end

    // Each level held 4 clocks so the device synchroniser sees it;
    // the serial clock stands still high between frames
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 1'b0;
            din = tx[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            rx = {rx[14:0], miso};
        end
        cs_n = 1'b1;
        // Deselected line must not keep looking valid
        din = ~din;
        repeat (4) @(negedge clk);
    endtask
endmodule // scal_spi_host

// >>> verification/tb_scal_top.sv
// Self-checking bench for the sensor output calibration block
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("[FAIL] %s exp %h got %h", nm, exp, got); \
        end \
    end
module tb_scal_top;
    // ****************************************************************
    // Design, host and stimulus
    // ****************************************************************
    logic CLOCK = 1'b0;
    logic RESET_N = 1'b0;
    logic RAW_VALID = 1'b0;
    logic NV_LOAD = 1'b0;
    logic [2:0] NV_INDEX = 3'h0;
    logic [15:0] NV_WORD_IN = 16'h0000;
    logic signed [13:0] raw [4] = '{14'sh0, 14'sh0, 14'sh0, 14'sh0};
    wire SCLK, CS_N, DIN, DOUT, DOUT_OE, NV_STORE, miso;
    wire [15:0] NV_WORD_OUT;
    int num_errors = 0;
    int checked = 0;
    int nv_pulses = 0;
    logic [15:0] t_off [4] = '{16'h07ff, 16'h0800, 16'h0100, 16'h00ff};
    logic [15:0] t_gain [4] = '{16'h0fff, 16'h0fff, 16'h0400, 16'h0c00};
    logic signed [13:0] t_raw [4] = '{14'sd8191, -14'sd8192, 14'sd1000,
        -14'sd37};
    logic signed [13:0] n_raw [4] = '{14'sd100, -14'sd300, 14'sd50,
        -14'sd255};

    always #2.5 CLOCK = ~CLOCK;
    // No pull-up on the data out line; released means undriven
    assign miso = DOUT_OE ? DOUT : 1'bz;
    always @(posedge CLOCK)
        if (NV_STORE === 1'b1)
            nv_pulses++;

    scal_top scal_top_inst (.CLOCK(CLOCK), .RESET_N(RESET_N), .SCLK(SCLK),
        .CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE),
        .RAW_VALID(RAW_VALID), .RAW_ACC_X(raw[0]), .RAW_ACC_Y(raw[1]),
        .RAW_TLT_X(raw[2]), .RAW_TLT_Y(raw[3]), .NV_LOAD(NV_LOAD),
        .NV_INDEX(NV_INDEX), .NV_WORD_IN(NV_WORD_IN), .NV_STORE(NV_STORE),
        .NV_WORD_OUT(NV_WORD_OUT));
    scal_spi_host scal_spi_host_inst (.clk(CLOCK), .sclk(SCLK),
        .cs_n(CS_N), .din(DIN), .miso(miso));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] fmask(int ch);
        return (ch < 2) ? 16'h0fff : 16'h01ff;
    endfunction

    function automatic logic [15:0] calc(logic signed [13:0] r,
        logic [15:0] off, logic [15:0] g, int w);
        int o;
        int p;
        o = int'(off);
        if (off[w-1])
            o -= 1 << w;
        p = (int'(r) + o) * int'(g & 16'h0fff);
        p = p >>> 11;
        if (p > 8191)
            p = 8191;
        if (p < -8192)
            p = -8192;
        return 16'(p);
    endfunction

    // Read answer arrives in the following frame
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        scal_spi_host_inst.xfer({2'b00, a, 8'h00}, d);
        scal_spi_host_inst.xfer(16'h0000, d);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] b);
        logic [15:0] d;
        scal_spi_host_inst.xfer({2'b10, a, b}, d);
    endtask

    task automatic wr16(input logic [5:0] a, input logic [15:0] w);
        wr({a[5:1], 1'b1}, w[15:8]);
        wr(a, w[7:0]);
    endtask

    task automatic set_raw(input logic signed [13:0] v [4]);
        @(negedge CLOCK);
        raw = v;
        RAW_VALID = 1'b1;
        @(negedge CLOCK);
        RAW_VALID = 1'b0;
    endtask

    task automatic final_report();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        logic [15:0] d;
        for (int ch = 0; ch < 4; ch++)
        begin
            rd(scal_pkg::OFF_ADR[ch], d);
            `CHK("offset reset", 16'h0000, d);
            rd(scal_pkg::GAIN_ADR[ch], d);
            `CHK("gain reset", 16'h0800, d);
        end
        `CHK("line released", 1'b0, DOUT_OE);
        set_raw(t_raw);
        rd(scal_pkg::RES_ADR[0], d);
        `CHK("unity result", calc(t_raw[0], 16'h0, 16'h0800, 12), d);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [15:0] d;
        for (int ch = 0; ch < 4; ch++)
        begin
            wr16(scal_pkg::OFF_ADR[ch], 16'hffff);
            wr16(scal_pkg::GAIN_ADR[ch], 16'hffff);
            rd(scal_pkg::OFF_ADR[ch] | 6'h01, d);
            `CHK("offset field", fmask(ch), d);
            rd(scal_pkg::GAIN_ADR[ch] | 6'h01, d);
            `CHK("gain odd read", 16'h0fff, d);
        end
        $display("test registers done");
    endtask

    task automatic t_calc();
        logic [15:0] d;
        logic [15:0] e;
        for (int ch = 0; ch < 4; ch++)
        begin
            wr16(scal_pkg::OFF_ADR[ch], t_off[ch]);
            wr16(scal_pkg::GAIN_ADR[ch], t_gain[ch]);
        end
        set_raw(t_raw);
        for (int ch = 0; ch < 4; ch++)
        begin
            rd(scal_pkg::RES_ADR[ch], d);
            e = calc(t_raw[ch], t_off[ch], t_gain[ch], ch < 2 ? 12 : 9);
            `CHK("result", e, d);
        end
        $display("test arithmetic done");
    endtask

    task automatic t_null();
        logic [15:0] d;
        logic [15:0] e;
        logic signed [13:0] z [4] = '{14'sh0, 14'sh0, 14'sh0, 14'sh0};
        set_raw(n_raw);
        // Averaging count to 08h first; this block ignores that address
        wr(6'h38, 8'h08);
        wr(scal_pkg::ADR_CMD, 8'h01);
        for (int ch = 0; ch < 4; ch++)
        begin
            rd(scal_pkg::RES_ADR[ch], d);
            `CHK("nulled result", 16'h0000, d);
            rd(scal_pkg::OFF_ADR[ch], d);
            `CHK("nulled offset", 16'(-n_raw[ch]) & fmask(ch), d);
        end
        set_raw(n_raw);
        rd(scal_pkg::RES_ADR[3], d);
        `CHK("result after null", 16'h0000, d);
        // Unity gain and zero input leave only the negative null offset
        wr16(scal_pkg::GAIN_ADR[0], 16'h0800);
        set_raw(z);
        rd(scal_pkg::RES_ADR[0], d);
        e = calc(14'sh0, 16'(-n_raw[0]) & fmask(0), 16'h0800, 12);
        `CHK("negative offset", e, d);
        $display("test null done");
    endtask

    task automatic t_nv();
        logic [15:0] d;
        wr(scal_pkg::ADR_CMD, 8'h08);
        `CHK("store pulses", 1, nv_pulses);
        @(negedge CLOCK);
        NV_INDEX = 3'h4;
        NV_WORD_IN = 16'hf234;
        NV_LOAD = 1'b1;
        @(negedge CLOCK);
        NV_LOAD = 1'b0;
        repeat (2) @(negedge CLOCK);
        `CHK("store readback", 16'h0234, NV_WORD_OUT);
        rd(scal_pkg::GAIN_ADR[0], d);
        `CHK("restored gain", 16'h0234, d);
        $display("test store done");
    endtask

    initial
    begin
        #400us;
        num_errors++;
        $display("[FAIL] run timeout");
        final_report();
    end

    initial
    begin
        repeat (6) @(negedge CLOCK);
        RESET_N = 1'b1;
        repeat (4) @(negedge CLOCK);
        t_reset();
        t_regs();
        t_calc();
        t_null();
        t_nv();
        final_report();
    end
endmodule // tb_scal_top
